/* File: design/pin_share_pkg.sv */
// package: constants and carriers for the isa/ide/local-bus pin sharing block
// Summary of operation
// - primary master and slave ide selects are driven active high.
// - secondary master and slave ide selects are driven active high.
// - three ide register address lines are presented for the drives.
// - in ide mode shared isa address pins 19..8 carry ide data 11..0.
// - side select 0 gives isa, 1 gives ide; four select pins carry data 15..12.
// - in ide mode the channel ready pin is the drive ready input.
// - separate interrupt inputs from primary and secondary ide channels.
// - independent dma request inputs from each ide channel.
// - separate active-low dma acknowledge per channel, asserted with the strobe of an is_dma request from the controller.
// - separate active-low read and write strobes per channel.
// - local-bus mode reuses isa data and dma request pins for data and address.
// - the data transceiver output enable is active low and goes high only during ide read cycles.
package pin_share_pkg;
   localparam logic side_isa = 1'b0;
   localparam logic side_ide = 1'b1;
   localparam logic [1:0] chan_primary = 2'h1;
   localparam logic [1:0] chan_secondary = 2'h2;

   typedef enum logic [3:0]
   {
      st_isa = 4'h1,
      st_switch = 4'h2,
      st_ide = 4'h4,
      st_strobe = 4'h8
   } mode_e;

   // one ide request from the internal controller
   typedef struct packed
   {
      logic secondary;
      logic is_write;
      logic is_dma;
      logic slave;
      logic [2:0] addr;
      logic [15:0] wdata;
   } ide_req_s;

   // pins facing the shared isa/ide lines
   typedef struct packed
   {
      logic side;
      logic [3:0] cs;
      logic [2:0] da;
      logic [15:0] dd;
      logic dd_oe_n;
      logic pr_n;
      logic pw_n;
      logic sr_n;
      logic sw_n;
      logic pack_n;
      logic sack_n;
   } ide_pins_s;
endpackage : pin_share_pkg

/* File: design/isa_ide_local_bus_pin_sharing.sv */
// file: isa/ide/local-bus shared pin multiplexer with ide cycle sequencer
`timescale 1ns/1ps
module isa_ide_local_bus_pin_sharing
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // internal isa side values
   input wire logic isa_busy_in,
   input wire logic [19:8] isa_addr_hi_in,
   input wire logic [23:17] isa_la_in,
   input wire logic [3:0] isa_xbus_sel_in,
   // internal local-bus side values
   input wire logic local_bus_mode_in,
   input wire logic [15:0] isa_data_in,
   input wire logic [15:0] local_bus_data_in,
   input wire logic [21:20] local_bus_address_in,
   input wire logic [1:0] muxed_dma_requests_in,
   // internal ide request port
   input wire logic ide_req_valid_in,
   input wire pin_share_pkg::ide_req_s ide_req_in,
   output logic ide_req_ready_out,
   output logic ide_done_out,
   output logic [15:0] ide_rdata_out,
   // shared pins inputs
   input wire logic [15:0] shared_dd_in,
   input wire logic channel_ready_in,
   input wire logic primary_channel_irq_in,
   input wire logic secondary_channel_irq_in,
   input wire logic primary_channel_dma_req_in,
   input wire logic secondary_channel_dma_req_in,
   // shared pins outputs
   output logic isa_ide_side_select_n_out,
   output logic [19:8] shared_sa_out,
   output logic [3:0] shared_xbus_out,
   output logic shared_xbus_oe_n_out,
   output logic primary_master_select_out,
   output logic primary_slave_select_out,
   output logic secondary_master_select_out,
   output logic secondary_slave_select_out,
   output logic [2:0] ide_addr_out,
   output logic primary_channel_read_n_out,
   output logic primary_channel_write_n_out,
   output logic secondary_channel_read_n_out,
   output logic secondary_channel_write_n_out,
   output logic primary_channel_dma_ack_n_out,
   output logic secondary_channel_dma_ack_n_out,
   // local-bus shared isa pins
   output logic [15:0] isa_sd_out,
   output logic [1:0] dma_req_pins_out,
   // status to the core
   output logic [1:0] ide_irq_out,
   output logic [1:0] ide_dma_pending_out
);

   typedef struct packed
   {
      pin_share_pkg::mode_e mode;
      pin_share_pkg::ide_req_s req;
      pin_share_pkg::ide_pins_s pins;
      logic [19:8] sa;
      logic [3:0] xb;
      logic [15:0] sd;
      logic [1:0] drq_pins;
      logic [1:0] irq;
      logic [1:0] dmap;
      logic ready;
      logic done;
      logic [15:0] rdata;
   } state_s;

   state_s cur;
   state_s next_cur;

   function automatic logic strobes_idle(input pin_share_pkg::ide_pins_s p);
      strobes_idle = p.pr_n & p.pw_n & p.sr_n & p.sw_n;
   endfunction : strobes_idle

   always_comb
   begin
      next_cur = cur;
      next_cur.done = 1'b0;
      next_cur.irq = {secondary_channel_irq_in, primary_channel_irq_in};
      next_cur.dmap = {secondary_channel_dma_req_in, primary_channel_dma_req_in};
      next_cur.sd = local_bus_mode_in ? local_bus_data_in : isa_data_in;
      next_cur.drq_pins = local_bus_mode_in ? local_bus_address_in : muxed_dma_requests_in;
      next_cur.ready = 1'b0;
      case (cur.mode)
         pin_share_pkg::st_isa:
         begin
            next_cur.sa = isa_addr_hi_in;
            next_cur.xb = isa_xbus_sel_in;
            next_cur.pins.cs = 4'h0;
            next_cur.pins.da = isa_la_in[19:17];
            next_cur.pins.dd_oe_n = 1'b0;
            if (ide_req_valid_in && !isa_busy_in)
            begin
               next_cur.ready = 1'b1;
               next_cur.req = ide_req_in;
               next_cur.mode = pin_share_pkg::st_switch;
            end
         end
         pin_share_pkg::st_switch:
         begin
            // side flips only with every strobe idle
            next_cur.pins.side = pin_share_pkg::side_ide;
            next_cur.pins.da = cur.req.addr;
            next_cur.pins.cs = cur.req.secondary ? (cur.req.slave ? 4'h8 : 4'h4)
                                                 : (cur.req.slave ? 4'h2 : 4'h1);
            next_cur.pins.dd_oe_n = ~cur.req.is_write;
            next_cur.sa = cur.req.wdata[11:0];
            next_cur.xb = cur.req.wdata[15:12];
            next_cur.mode = pin_share_pkg::st_strobe;
         end
         pin_share_pkg::st_strobe:
         begin
            next_cur.pins.pr_n = ~(!cur.req.secondary && !cur.req.is_write);
            next_cur.pins.pw_n = ~(!cur.req.secondary && cur.req.is_write);
            next_cur.pins.sr_n = ~(cur.req.secondary && !cur.req.is_write);
            next_cur.pins.sw_n = ~(cur.req.secondary && cur.req.is_write);
            next_cur.pins.pack_n = ~(cur.req.is_dma && !cur.req.secondary);
            next_cur.pins.sack_n = ~(cur.req.is_dma && cur.req.secondary);
            if (!strobes_idle(cur.pins) && channel_ready_in)
            begin
               next_cur.rdata = shared_dd_in;
               next_cur.pins.pr_n = 1'b1;
               next_cur.pins.pw_n = 1'b1;
               next_cur.pins.sr_n = 1'b1;
               next_cur.pins.sw_n = 1'b1;
               next_cur.pins.pack_n = 1'b1;
               next_cur.pins.sack_n = 1'b1;
               next_cur.done = 1'b1;
               next_cur.mode = pin_share_pkg::st_ide;
            end
         end
         pin_share_pkg::st_ide:
         begin
            next_cur.pins.cs = 4'h0;
            next_cur.pins.dd_oe_n = 1'b0;
            next_cur.pins.side = pin_share_pkg::side_isa;
            next_cur.mode = pin_share_pkg::st_isa;
         end
         default:
            next_cur.mode = pin_share_pkg::st_isa;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         cur <= '0;
         cur.mode <= pin_share_pkg::st_isa;
         cur.pins.pr_n <= 1'b1;
         cur.pins.pw_n <= 1'b1;
         cur.pins.sr_n <= 1'b1;
         cur.pins.sw_n <= 1'b1;
         cur.pins.pack_n <= 1'b1;
         cur.pins.sack_n <= 1'b1;
      end
      else
         cur <= next_cur;
   end

   // output side select is active-low isa enable: high selects ide
   assign isa_ide_side_select_n_out = cur.pins.side;
   assign shared_sa_out = cur.sa;
   assign shared_xbus_out = cur.xb;
   assign shared_xbus_oe_n_out = cur.pins.dd_oe_n;
   assign primary_master_select_out = cur.pins.cs[0];
   assign primary_slave_select_out = cur.pins.cs[1];
   assign secondary_master_select_out = cur.pins.cs[2];
   assign secondary_slave_select_out = cur.pins.cs[3];
   assign ide_addr_out = cur.pins.da;
   assign primary_channel_read_n_out = cur.pins.pr_n;
   assign primary_channel_write_n_out = cur.pins.pw_n;
   assign secondary_channel_read_n_out = cur.pins.sr_n;
   assign secondary_channel_write_n_out = cur.pins.sw_n;
   assign primary_channel_dma_ack_n_out = cur.pins.pack_n;
   assign secondary_channel_dma_ack_n_out = cur.pins.sack_n;
   assign isa_sd_out = cur.sd;
   assign dma_req_pins_out = cur.drq_pins;
   assign ide_irq_out = cur.irq;
   assign ide_dma_pending_out = cur.dmap;
   assign ide_req_ready_out = cur.ready;
   assign ide_done_out = cur.done;
   assign ide_rdata_out = cur.rdata;

   sequence strobe_on_s;
      !strobes_idle(cur.pins);
   endsequence

   side_stable_a: assert property (@(posedge clock_in) disable iff (rst_in)
      $changed(cur.pins.side) |-> strobes_idle(cur.pins) && $past(strobes_idle(cur.pins)))
      else $error("side select changed with strobe active");
   strobe_side_a: assert property (@(posedge clock_in) disable iff (rst_in)
      strobe_on_s |-> cur.pins.side == pin_share_pkg::side_ide)
      else $error("ide strobe while isa side");
   cs_isa_a: assert property (@(posedge clock_in) disable iff (rst_in)
      cur.mode == pin_share_pkg::st_isa |-> cur.pins.cs == 4'h0)
      else $error("chip select active in isa mode");
   cs_onehot_a: assert property (@(posedge clock_in) disable iff (rst_in)
      strobe_on_s |-> $onehot(cur.pins.cs))
      else $error("chip select not one-hot during strobe");
   ready_end_a: assert property (@(posedge clock_in) disable iff (rst_in)
      strobe_on_s and channel_ready_in |=> strobes_idle(cur.pins) && cur.done)
      else $error("ready did not end strobe");
   wait_hold_a: assert property (@(posedge clock_in) disable iff (rst_in)
      strobe_on_s and !channel_ready_in |=> !strobes_idle(cur.pins))
      else $error("strobe dropped without ready");
   ack_dma_a: assert property (@(posedge clock_in) disable iff (rst_in)
      !cur.pins.pack_n |-> !cur.req.secondary && cur.req.is_dma && cur.pins.sack_n)
      else $error("bad primary ack");
   one_strobe_a: assert property (@(posedge clock_in) disable iff (rst_in)
      strobe_on_s |-> $onehot({cur.pins.pr_n, cur.pins.pw_n, cur.pins.sr_n, cur.pins.sw_n} ^ 4'hf))
      else $error("more than one strobe");
   data_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
      cur.mode == pin_share_pkg::st_switch |=> cur.sa == $past(cur.req.wdata[11:0]))
      else $error("ide data not on shared address pins");
   local_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
      local_bus_mode_in |=> cur.sd == $past(local_bus_data_in))
      else $error("local data not on isa data pins");
   irq_pass_a: assert property (@(posedge clock_in) disable iff (rst_in)
      1'b1 |=> cur.irq == $past({secondary_channel_irq_in, primary_channel_irq_in}))
      else $error("irq not passed");
   drq_pass_a: assert property (@(posedge clock_in) disable iff (rst_in)
      1'b1 |=> cur.dmap == $past({secondary_channel_dma_req_in, primary_channel_dma_req_in}))
      else $error("dma request not passed");
   addr_map_a: assert property (@(posedge clock_in) disable iff (rst_in)
      cur.mode == pin_share_pkg::st_switch |=> cur.pins.da == $past(cur.req.addr))
      else $error("ide address not presented");
endmodule : isa_ide_local_bus_pin_sharing

/* File: verification/ide_drive_model.sv */
// partner: ide drive seen through the external gating glue
`timescale 1ns/1ps
module ide_drive_model
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // pins from the device
   input wire logic side_in,
   input wire logic [3:0] sel_in,
   input wire logic [2:0] addr_in,
   input wire logic [3:0] strobe_n_in,
   input wire logic [1:0] ack_n_in,
   // stall and read data from the bench
   input wire logic [3:0] wait_in,
   input wire logic [15:0] data_in,
   // pins to the device
   output logic [15:0] dd_out,
   output logic ready_out
);
   logic [3:0] cnt;
   logic [15:0] last;
   logic [3:0] sel_seen;
   logic [2:0] addr_seen;
   logic reading;
   assign sel_seen = sel_in & {4{side_in}};
   assign addr_seen = addr_in | {3{~side_in}};
   assign reading = (|sel_seen || ack_n_in != 2'h3) && !(strobe_n_in[3] && strobe_n_in[1]);
   assign ready_out = (&strobe_n_in) || cnt >= wait_in;
   // released bus shows a changing pattern
   assign dd_out = reading ? data_in ^ {13'h0, addr_seen} : ~last;
   always_ff @(posedge clock_in)
   begin
      cnt <= (rst_in || &strobe_n_in) ? 4'h0 : cnt + 4'h1;
      last <= rst_in ? 16'h0 : dd_out;
   end
endmodule : ide_drive_model

/* File: verification/tb_isa_ide_local_bus_pin_sharing.sv */
// testbench: ide transfers and isa/local-bus pin sharing
`timescale 1ns/1ps
module tb_isa_ide_local_bus_pin_sharing;
   logic clock_in, rst_in, busy, lbm, valid, side, oe_n, ready, done, cs0, cs1, cs2, cs3, pr, pw, sr, sw, pa, sa_n, rdy;
   logic [11:0] hi, sa;
   logic [3:0] xsel, xb, wt;
   logic [15:0] isa_d, lb_d, rd, rdata, dd, sd;
   logic [1:0] lb_a, mdr, irq, drq, dp, irq_o, pend;
   logic [2:0] da;
   logic [6:0] la;
   pin_share_pkg::ide_req_s req;
   int fails, tests_run;
   isa_ide_local_bus_pin_sharing DUT
   (
      .clock_in(clock_in), .rst_in(rst_in), .isa_busy_in(busy), .isa_addr_hi_in(hi), .isa_la_in(la),
      .isa_xbus_sel_in(xsel), .local_bus_mode_in(lbm), .isa_data_in(isa_d), .local_bus_data_in(lb_d),
      .local_bus_address_in(lb_a), .muxed_dma_requests_in(mdr), .ide_req_valid_in(valid), .ide_req_in(req),
      .ide_req_ready_out(ready), .ide_done_out(done), .ide_rdata_out(rdata), .shared_dd_in(dd),
      .channel_ready_in(rdy), .primary_channel_irq_in(irq[0]), .secondary_channel_irq_in(irq[1]),
      .primary_channel_dma_req_in(drq[0]), .secondary_channel_dma_req_in(drq[1]),
      .isa_ide_side_select_n_out(side), .shared_sa_out(sa), .shared_xbus_out(xb), .shared_xbus_oe_n_out(oe_n),
      .primary_master_select_out(cs0), .primary_slave_select_out(cs1), .secondary_master_select_out(cs2),
      .secondary_slave_select_out(cs3), .ide_addr_out(da), .primary_channel_read_n_out(pr),
      .primary_channel_write_n_out(pw), .secondary_channel_read_n_out(sr), .secondary_channel_write_n_out(sw),
      .primary_channel_dma_ack_n_out(pa), .secondary_channel_dma_ack_n_out(sa_n), .isa_sd_out(sd),
      .dma_req_pins_out(dp), .ide_irq_out(irq_o), .ide_dma_pending_out(pend)
   );
   ide_drive_model far_end
   (
      .clock_in(clock_in), .rst_in(rst_in), .side_in(side), .sel_in({cs3, cs2, cs1, cs0}), .addr_in(da),
      .strobe_n_in({pr, pw, sr, sw}), .ack_n_in({sa_n, pa}), .wait_in(wt), .data_in(rd), .dd_out(dd),
      .ready_out(rdy)
   );
   initial
   begin
      clock_in = 1'b0;
      forever #2.5 clock_in = ~clock_in;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic hang(input string what);
      fails++;
      $display("mismatch at %0t: no response, %s", $time, what);
      tally_and_finish();
   endtask : hang
   task automatic xfer(input pin_share_pkg::ide_req_s r, input logic [3:0] w, input logic [15:0] d);
      int n;
      logic [3:0] es;
      es = 4'hf;
      es[{~r.secondary, ~r.is_write}] = 1'b0;
      @(posedge clock_in);
      valid <= 1'b1;
      req <= r;
      wt <= w;
      rd <= d;
      for (n = 0; ready !== 1'b1; n++)
      begin
         if (n > 20)
            hang("ready");
         @(negedge clock_in);
      end
      @(posedge clock_in);
      valid <= 1'b0;
      for (n = 0; {pr, pw, sr, sw} !== es; n++)
      begin
         if (n > 20)
            hang("strobe");
         @(negedge clock_in);
      end
      check(16'(side), 16'h1, "side");
      check(16'({sa_n, pa}), 16'({~(r.is_dma & r.secondary), ~(r.is_dma & ~r.secondary)}), "ack");
      if (!r.is_dma)
         check(16'({cs3, cs2, cs1, cs0}), 16'(4'h1 << {r.secondary, r.slave}), "select");
      check(16'(da), 16'(r.addr), "addr");
      check(16'(oe_n), 16'(!r.is_write), "oe");
      if (r.is_write)
         check({xb, sa}, r.wdata, "wdata");
      for (n = 0; {pr, pw, sr, sw} === es && side === 1'b1 && n < 20; n++)
         @(negedge clock_in);
      check(16'(n), 16'(w + 4'h1), "stretch");
      check(16'({pr, pw, sr, sw, done, side}), 16'h3f, "release");
      if (!r.is_write)
         check(rdata, d ^ 16'(r.addr), "rdata");
      @(negedge clock_in);
      check(16'(side), 16'h0, "back to isa");
   endtask : xfer
   task automatic refused();
      @(posedge clock_in);
      busy <= 1'b1;
      valid <= 1'b1;
      req <= {4'h0, 3'h3, 16'h0};
      repeat (6)
      begin
         @(negedge clock_in);
         check(16'({ready, side}), 16'h0, "refused");
      end
      @(posedge clock_in);
      busy <= 1'b0;
      valid <= 1'b0;
   endtask : refused
   task automatic pins();
      @(posedge clock_in);
      hi <= 12'ha5c;
      xsel <= 4'h9;
      la <= 7'h55;
      repeat (3) @(negedge clock_in);
      check({xb, sa}, 16'h9a5c, "isa pins");
      check(16'(da), 16'h5, "isa la pins");
      check(sd, 16'h1234, "isa data");
      check(16'(dp), 16'h1, "dma pins");
      @(posedge clock_in);
      lbm <= 1'b1;
      repeat (3) @(negedge clock_in);
      check(sd, 16'hbeef, "local bus data");
      check(16'(dp), 16'h2, "local bus address");
   endtask : pins
   task automatic irqs();
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock_in);
         irq <= 2'(i);
         drq <= 2'(3 - i);
         repeat (2) @(negedge clock_in);
         check(16'({irq_o, pend}), 16'({2'(i), 2'(3 - i)}), "irq dma");
      end
   endtask : irqs
   initial
   begin
      fails = 0;
      tests_run = 0;
      {rst_in, busy, lbm, valid, hi, xsel, wt, rd, req} = {1'b1, 62'h0};
      {isa_d, lb_d, lb_a, mdr, irq, drq} = {16'h1234, 16'hbeef, 2'h2, 2'h1, 4'h0};
      la = 7'h0;
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      @(negedge clock_in);
      check(16'({side, cs3, cs2, cs1, cs0, pr, pw, sr, sw, pa, sa_n}), 16'h03f, "reset");
      refused();
      xfer({4'h0, 3'h7, 16'h0}, 4'h0, 16'ha55a);
      xfer({4'h5, 3'h2, 16'hc3e1}, 4'h1, 16'h0);
      xfer({4'hc, 3'h5, 16'h8001}, 4'h0, 16'h0);
      xfer({4'h9, 3'h1, 16'h0}, 4'h2, 16'h7ffe);
      xfer({4'h6, 3'h0, 16'h5aa5}, 4'h0, 16'h0);
      xfer({4'ha, 3'h0, 16'h0}, 4'h3, 16'h0ff0);
      pins();
      irqs();
      tally_and_finish();
   end
endmodule : tb_isa_ide_local_bus_pin_sharing
